// ---- lad_defines.svh ----
`ifndef LAD_DEFINES_SVH
`define LAD_DEFINES_SVH

`define LAD_HI_ADD     8'h0F
`define LAD_HI_AND     8'h0B
`define LAD_HI_OR      8'h09
`define LAD_HI_XOR     8'h0A
`define LAD_HI_SUB     8'h08
`define LAD_HI_MOV     8'h0E
`define LAD_HI_MUL     8'h0D
`define LAD_HI_RET     8'h0C
`define LAD_HI_PTR1    8'hEE
`define LAD_HI_BANK    8'h01
`define LAD_HI_TBL     8'h00
`define LAD_TBL_RD     6'h02
`define LAD_TBL_WR     6'h03
`define LAD_PTR2_NIB   4'hF

`define LAD_REG_WORKING_REGISTER   4'h0
`define LAD_REG_STATUS 4'h1
`define LAD_REG_BANK   4'h2
`define LAD_REG_PTR0   4'h3
`define LAD_REG_PTR1   4'h4
`define LAD_REG_PTR2   4'h5
`define LAD_REG_TPTR   4'h6
`define LAD_REG_TLAT   4'h7
`define LAD_REG_PROD   4'h8
`define LAD_REG_CTRL   4'h9
`define LAD_REG_PINS   4'hA

`define LAD_CTRL_PSA   0
`define LAD_RST_BYTE   8'h00
`define LAD_RST_WORD   16'h0000

`endif

// ---- lad_pkg.sv ----
package lad_pkg;
`include "lad_defines.svh"

   typedef enum logic [3:0] {
      OP_NOP, OP_ADD, OP_AND, OP_OR, OP_XOR, OP_SUB, OP_MOV, OP_MUL,
      OP_BANK, OP_RET, OP_PTR1, OP_PTR2, OP_TRD, OP_TWR
   } lad_op_t;

   // order matches the low two bits of a table op
   typedef enum logic [1:0] {
      TM_PLAIN, TM_POSTINC, TM_POSTDEC, TM_PREINC
   } lad_tmode_t;

   typedef struct packed {
      logic neg;
      logic ovf;
      logic zero;
      logic dc;
      logic carry;
   } lad_flags_t;

   function automatic lad_op_t lad_decode(input logic [15:0] w);
      lad_op_t op;
      op = OP_NOP;
      case (w[15:8])
         `LAD_HI_ADD:  op = OP_ADD;
         `LAD_HI_AND:  op = OP_AND;
         `LAD_HI_OR:   op = OP_OR;
         `LAD_HI_XOR:  op = OP_XOR;
         `LAD_HI_SUB:  op = OP_SUB;
         `LAD_HI_MOV:  op = OP_MOV;
         `LAD_HI_MUL:  op = OP_MUL;
         `LAD_HI_RET:  op = OP_RET;
         `LAD_HI_PTR1: op = (w[7:6] == 2'h0) ? OP_PTR1 : OP_NOP;
         `LAD_HI_BANK: op = (w[7:4] == 4'h0) ? OP_BANK : OP_NOP;
         `LAD_HI_TBL: begin
            if (w[7:2] == `LAD_TBL_RD)
               op = OP_TRD;
            else if (w[7:2] == `LAD_TBL_WR)
               op = OP_TWR;
         end
         default: begin
            if (w[15:12] == `LAD_PTR2_NIB)
               op = OP_PTR2;
         end
      endcase
      return op;
   endfunction
endpackage

// ---- lad_alu.sv ----
`timescale 1ns/1ps
module lad_alu (
   input  wire lad_pkg::lad_op_t    i_op,
   input  wire logic [7:0]          i_working_register,
   input  wire logic [7:0]          i_lit,
   input  wire lad_pkg::lad_flags_t i_flags,
   output logic [7:0]               o_res,
   output lad_pkg::lad_flags_t      o_flags,
   output logic [15:0]              o_prod
);
   logic [7:0] opnd_b;
   logic       cin;
   logic [8:0] sum9;
   logic [4:0] nib5;

   // subtract as k + ~W + 1 so carry means no borrow
   always_comb begin
      cin    = (i_op == lad_pkg::OP_SUB);
      opnd_b = cin ? ~i_working_register : i_working_register;
      sum9   = {1'b0, i_lit} + {1'b0, opnd_b} + {8'h00, cin};
      nib5   = {1'b0, i_lit[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, cin};
      o_prod = i_working_register * i_lit;
      o_res  = i_working_register;
      o_flags = i_flags;
      case (i_op)
         lad_pkg::OP_ADD, lad_pkg::OP_SUB: begin
            o_res         = sum9[7:0];
            o_flags.carry = sum9[8];
            o_flags.dc    = nib5[4];
            o_flags.ovf   = (i_lit[7] == opnd_b[7]) &&
                            (sum9[7] != i_lit[7]);
         end
         lad_pkg::OP_AND: o_res = i_working_register & i_lit;
         lad_pkg::OP_OR:  o_res = i_working_register | i_lit;
         lad_pkg::OP_XOR: o_res = i_working_register ^ i_lit;
         lad_pkg::OP_MOV: o_res = i_lit;
         default:         o_res = i_working_register;
      endcase
      case (i_op)
         lad_pkg::OP_ADD, lad_pkg::OP_SUB, lad_pkg::OP_AND,
         lad_pkg::OP_OR, lad_pkg::OP_XOR: begin
            o_flags.zero = (o_res == 8'h00);
            o_flags.neg  = o_res[7];
         end
         default: o_flags.zero = i_flags.zero;
      endcase
   end
endmodule // lad_alu

// ---- lad_tblptr.sv ----
`timescale 1ns/1ps
module lad_tblptr #(
   parameter int TP_W = 16
) (
   input  wire lad_pkg::lad_tmode_t i_mode,
   input  wire logic [TP_W-1:0]     i_ptr,
   output logic [TP_W-1:0]          o_addr,
   output logic [TP_W-1:0]          o_nxt
);
   localparam logic [TP_W-1:0] ONE = TP_W'(1);

   if (TP_W < 2 || TP_W > 16) begin : g_chk
      $error("table pointer width must be 2..16");
   end

   always_comb begin
      o_addr = i_ptr;
      o_nxt  = i_ptr;
      unique case (i_mode)
         lad_pkg::TM_PLAIN:   o_nxt = i_ptr;
         lad_pkg::TM_POSTINC: o_nxt = i_ptr + ONE;
         lad_pkg::TM_POSTDEC: o_nxt = i_ptr - ONE;
         lad_pkg::TM_PREINC: begin
            o_nxt  = i_ptr + ONE;
            o_addr = i_ptr + ONE;
         end
      endcase
   end
endmodule // lad_tblptr

// ---- lad_decoder.sv ----
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module lad_decoder #(
   parameter int TP_W = 16
) (
   input  wire logic                i_clk,
   input  wire logic                i_rst,
   input  wire logic                i_ce,
   input  wire logic                i_instr_valid,
   input  wire logic [15:0]         i_instr,
   input  wire logic [7:0]          i_prog_byte,
   input  wire logic [7:0]          i_port_pins,
   input  wire logic [7:0]          i_port_latch,
   input  wire logic                i_port_self_mod,
   input  wire logic                i_timer_zero_count_write,
   input  wire logic [3:0]          i_bus_addr,
   input  wire logic [15:0]         i_bus_wdata,
   input  wire logic                i_bus_wr,
   input  wire logic                i_bus_rd,
   output logic [15:0]              o_bus_rdata_ff,
   output logic [7:0]               o_working_register_ff,
   output lad_pkg::lad_flags_t      o_status_ff,
   output logic [3:0]               o_bsr_ff,
   output logic [15:0]              o_prod_ff,
   output logic                     o_ret_ff,
   output logic                     o_flush_ff,
   output logic                     o_tbl_rd_ff,
   output logic                     o_tbl_wr_ff,
   output logic [TP_W-1:0]          o_tbl_addr_ff,
   output logic [7:0]               o_tbl_wdata_ff,
   output logic [7:0]               o_port_src_ff,
   output logic                     o_psc_clr_ff
);
   typedef enum logic [1:0] {ST_EXEC, ST_OPND, ST_NOP} lad_state_t;

   lad_state_t          state_ff;
   lad_pkg::lad_op_t    op;
   lad_pkg::lad_flags_t alu_flags;
   logic [7:0]          lit;
   logic [7:0]          alu_res;
   logic [15:0]         alu_prod;
   logic [TP_W-1:0]     tbl_ptr_ff;
   logic [TP_W-1:0]     tbl_addr;
   logic [TP_W-1:0]     tbl_nxt;
   logic [11:0]         fsr_ff [3];
   logic [1:0]          fsr_sel_ff;
   logic [3:0]          fsr_hi_ff;
   logic [7:0]          tlat_ff;
   logic                psa_ff;
   logic [7:0]          pins_s1_ff;
   logic [7:0]          pins_s2_ff;
   logic                fire;
   logic                opnd_fire;
   logic                alu_op;
   logic                bus_wr;

   assign lit       = i_instr[7:0];
   assign op        = lad_pkg::lad_decode(i_instr);
   assign fire      = i_ce && i_instr_valid && (state_ff == ST_EXEC);
   assign opnd_fire = i_ce && i_instr_valid && (state_ff == ST_OPND);
   assign bus_wr    = i_ce && i_bus_wr;
   assign alu_op    = op inside {lad_pkg::OP_ADD, lad_pkg::OP_AND,
                                 lad_pkg::OP_OR, lad_pkg::OP_XOR,
                                 lad_pkg::OP_SUB, lad_pkg::OP_MOV};

   lad_alu u_alu (
      .i_op    (op),
      .i_working_register  (o_working_register_ff),
      .i_lit   (lit),
      .i_flags (o_status_ff),
      .o_res   (alu_res),
      .o_flags (alu_flags),
      .o_prod  (alu_prod)
   );

   lad_tblptr #(.TP_W(TP_W)) u_tblptr (
      .i_mode (lad_pkg::lad_tmode_t'(i_instr[1:0])),
      .i_ptr  (tbl_ptr_ff),
      .o_addr (tbl_addr),
      .o_nxt  (tbl_nxt)
   );

   ////////////////////////////////////////////////////////////////////////
   // sequencing: a word taken in ST_NOP is the flushed slot and is dropped
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_ff <= ST_EXEC;
      end else if (i_ce) begin
         unique case (state_ff)
            ST_EXEC: begin
               if (fire && op == lad_pkg::OP_PTR1)
                  state_ff <= ST_OPND;
               else if (fire && op inside {lad_pkg::OP_RET,
                        lad_pkg::OP_TRD, lad_pkg::OP_TWR})
                  state_ff <= ST_NOP;
            end
            ST_OPND: begin
               if (i_instr_valid)
                  state_ff <= ST_EXEC;
            end
            ST_NOP: state_ff <= ST_EXEC;
            // two-bit code 3 is unused; recover to fetch
            default: state_ff <= ST_EXEC;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_ret_ff   <= 1'b0;
         o_flush_ff <= 1'b0;
      end else if (i_ce) begin
         o_ret_ff   <= fire && op == lad_pkg::OP_RET;
         o_flush_ff <= fire && op == lad_pkg::OP_RET;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // working register and flags; the instruction beats a bus write
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_working_register_ff <= `LAD_RST_BYTE;
      end else if (fire && alu_op) begin
         o_working_register_ff <= alu_res;
      end else if (fire && op == lad_pkg::OP_RET) begin
         o_working_register_ff <= lit;
      end else if (bus_wr && i_bus_addr == `LAD_REG_WORKING_REGISTER) begin
         o_working_register_ff <= i_bus_wdata[7:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_status_ff <= '0;
      end else if (fire && alu_op) begin
         o_status_ff <= alu_flags;
      end else if (bus_wr && i_bus_addr == `LAD_REG_STATUS) begin
         o_status_ff <= i_bus_wdata[4:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_prod_ff <= `LAD_RST_WORD;
      end else if (fire && op == lad_pkg::OP_MUL) begin
         o_prod_ff <= alu_prod;
      end else if (bus_wr && i_bus_addr == `LAD_REG_PROD) begin
         o_prod_ff <= i_bus_wdata;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_bsr_ff <= 4'h0;
      end else if (fire && op == lad_pkg::OP_BANK) begin
         o_bsr_ff <= i_instr[3:0];
      end else if (bus_wr && i_bus_addr == `LAD_REG_BANK) begin
         o_bsr_ff <= i_bus_wdata[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pointer load: first word holds select and top nibble
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         fsr_sel_ff <= 2'h0;
         fsr_hi_ff  <= 4'h0;
      end else if (fire && op == lad_pkg::OP_PTR1) begin
         fsr_sel_ff <= i_instr[5:4];
         fsr_hi_ff  <= i_instr[3:0];
      end
   end

   for (genvar g = 0; g < 3; g++) begin : g_fsr
      always_ff @(posedge i_clk) begin
         if (i_rst) begin
            fsr_ff[g] <= 12'h000;
         end else if (opnd_fire && fsr_sel_ff == 2'(g)) begin
            fsr_ff[g] <= {fsr_hi_ff, i_instr[7:0]};
         end else if (bus_wr && i_bus_addr == `LAD_REG_PTR0 + 4'(g)) begin
            fsr_ff[g] <= i_bus_wdata[11:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // table access: strobe and address stand in the no-op cycle
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tbl_ptr_ff <= '0;
      end else if (fire && op inside {lad_pkg::OP_TRD, lad_pkg::OP_TWR}) begin
         tbl_ptr_ff <= tbl_nxt;
      end else if (bus_wr && i_bus_addr == `LAD_REG_TPTR) begin
         tbl_ptr_ff <= i_bus_wdata[TP_W-1:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_tbl_rd_ff    <= 1'b0;
         o_tbl_wr_ff    <= 1'b0;
         o_tbl_addr_ff  <= '0;
         o_tbl_wdata_ff <= `LAD_RST_BYTE;
      end else if (i_ce) begin
         o_tbl_rd_ff <= fire && op == lad_pkg::OP_TRD;
         o_tbl_wr_ff <= fire && op == lad_pkg::OP_TWR;
         if (fire && op inside {lad_pkg::OP_TRD, lad_pkg::OP_TWR}) begin
            o_tbl_addr_ff  <= tbl_addr;
            o_tbl_wdata_ff <= tlat_ff;
         end
      end
   end

   // program memory answers within the strobe cycle
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tlat_ff <= `LAD_RST_BYTE;
      end else if (i_ce && o_tbl_rd_ff) begin
         tlat_ff <= i_prog_byte;
      end else if (bus_wr && i_bus_addr == `LAD_REG_TLAT) begin
         tlat_ff <= i_bus_wdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // port source and timer zero prescaler
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pins_s1_ff <= 8'h00;
         pins_s2_ff <= 8'h00;
      end else if (i_ce) begin
         pins_s1_ff <= i_port_pins;
         pins_s2_ff <= pins_s1_ff;
      end
   end

   // latch is ignored on self-modify: an input pin reads its real level
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_port_src_ff <= 8'h00;
      end else if (i_ce) begin
         o_port_src_ff <= i_port_self_mod ? pins_s2_ff : i_port_latch;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         psa_ff <= 1'b0;
      end else if (bus_wr && i_bus_addr == `LAD_REG_CTRL) begin
         psa_ff <= i_bus_wdata[`LAD_CTRL_PSA];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_psc_clr_ff <= 1'b0;
      end else if (i_ce) begin
         o_psc_clr_ff <= i_timer_zero_count_write && psa_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register read port, data one cycle after the strobe
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_bus_rdata_ff <= `LAD_RST_WORD;
      end else if (i_ce && i_bus_rd) begin
         case (i_bus_addr)
            `LAD_REG_WORKING_REGISTER:   o_bus_rdata_ff <= {8'h00, o_working_register_ff};
            `LAD_REG_STATUS: o_bus_rdata_ff <= {11'h000, o_status_ff};
            `LAD_REG_BANK:   o_bus_rdata_ff <= {12'h000, o_bsr_ff};
            `LAD_REG_PTR0:   o_bus_rdata_ff <= {4'h0, fsr_ff[0]};
            `LAD_REG_PTR1:   o_bus_rdata_ff <= {4'h0, fsr_ff[1]};
            `LAD_REG_PTR2:   o_bus_rdata_ff <= {4'h0, fsr_ff[2]};
            `LAD_REG_TPTR:   o_bus_rdata_ff <= 16'(tbl_ptr_ff);
            `LAD_REG_TLAT:   o_bus_rdata_ff <= {8'h00, tlat_ff};
            `LAD_REG_PROD:   o_bus_rdata_ff <= o_prod_ff;
            `LAD_REG_CTRL:   o_bus_rdata_ff <= {15'h0000, psa_ff};
            `LAD_REG_PINS:   o_bus_rdata_ff <= {8'h00, pins_s2_ff};
            default:         o_bus_rdata_ff <= `LAD_RST_WORD;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic [7:0]  add_sum;
   logic [7:0]  sub_dif;
   logic [15:0] mul_p;
   assign add_sum = o_working_register_ff + lit;
   assign sub_dif = lit - o_working_register_ff;
   assign mul_p   = o_working_register_ff * lit;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_add_result: assert property (fire && op == lad_pkg::OP_ADD |=>
      o_working_register_ff == $past(add_sum) && o_status_ff.zero == (o_working_register_ff == 8'h00))
      else $error("add literal result wrong");
   a_and_flags: assert property (fire && op == lad_pkg::OP_AND |=>
      o_working_register_ff == ($past(o_working_register_ff) & $past(lit)) &&
      o_status_ff.carry == $past(o_status_ff.carry))
      else $error("and literal wrong");
   a_or_result: assert property (fire && op == lad_pkg::OP_OR |=>
      o_working_register_ff == ($past(o_working_register_ff) | $past(lit)) &&
      o_status_ff.neg == o_working_register_ff[7])
      else $error("or literal wrong");
   a_xor_result: assert property (fire && op == lad_pkg::OP_XOR |=>
      o_working_register_ff == ($past(o_working_register_ff) ^ $past(lit)) &&
      o_status_ff.ovf == $past(o_status_ff.ovf))
      else $error("xor literal wrong");
   a_sub_result: assert property (fire && op == lad_pkg::OP_SUB |=>
      o_working_register_ff == $past(sub_dif) &&
      o_status_ff.carry == ($past(lit) >= $past(o_working_register_ff)))
      else $error("subtract from literal wrong");
   a_load_lit: assert property (fire && op == lad_pkg::OP_MOV |=>
      o_working_register_ff == $past(i_instr[7:0]) && $stable(o_status_ff))
      else $error("load literal wrong");
   a_mul_prod: assert property (fire && op == lad_pkg::OP_MUL |=>
      o_prod_ff == $past(mul_p) && $stable(o_status_ff))
      else $error("multiply product wrong");
   a_bank_load: assert property (fire && op == lad_pkg::OP_BANK |=>
      o_bsr_ff == $past(i_instr[3:0]))
      else $error("bank load wrong");
   a_ret_seq: assert property (fire && op == lad_pkg::OP_RET |=>
      o_ret_ff && o_flush_ff && o_working_register_ff == $past(lit) ##1 !o_ret_ff)
      else $error("return literal sequence wrong");
   a_ptr_load: assert property (fire && op == lad_pkg::OP_PTR1 ##1
      opnd_fire && fsr_sel_ff == 2'h1 |=>
      fsr_ff[1] == {$past(fsr_hi_ff), $past(i_instr[7:0])})
      else $error("pointer load wrong");
   a_tbl_read: assert property (fire && op == lad_pkg::OP_TRD &&
      i_instr[1:0] == 2'h1 |=> o_tbl_rd_ff &&
      o_tbl_addr_ff == $past(tbl_ptr_ff) &&
      tbl_ptr_ff == $past(tbl_ptr_ff) + TP_W'(1))
      else $error("table read post-increment wrong");
   a_tbl_write: assert property (fire && op == lad_pkg::OP_TWR |=>
      o_tbl_wr_ff && state_ff == ST_NOP && $stable(o_status_ff))
      else $error("table write wrong");
   a_port_src: assert property (i_ce && i_port_self_mod |=>
      o_port_src_ff == $past(pins_s2_ff))
      else $error("port source not from pins");
   a_psc_clear: assert property (i_ce && i_timer_zero_count_write && psa_ff |=>
      o_psc_clr_ff)
      else $error("prescaler not cleared");
   a_nop_slot: assert property (state_ff == ST_NOP && i_ce |=>
      state_ff == ST_EXEC && $stable(o_working_register_ff) || $past(bus_wr))
      else $error("second cycle not a no-op");
   a_stray_word: assert property (fire && op == lad_pkg::OP_PTR2 &&
      !i_bus_wr |=> $stable(o_working_register_ff) && state_ff == ST_EXEC)
      else $error("stray second word not a no-op");

   c_return: cover property (fire && op == lad_pkg::OP_RET ##2 fire);
   c_ptr_load: cover property (fire && op == lad_pkg::OP_PTR1 ##1 opnd_fire);
   c_tbl_read: cover property (o_tbl_rd_ff && i_ce);
   c_add_carry: cover property (fire && op == lad_pkg::OP_ADD ##1
      o_status_ff.carry);
endmodule // lad_decoder

// ---- lad_pmem.sv ----
`timescale 1ns/1ps
module lad_pmem (
   input  wire logic        i_clk,
   input  wire logic        i_rd,
   input  wire logic [15:0] i_addr,
   output logic [7:0]       o_byte
);
   logic [7:0] last_ff = 8'h00;
   // released bus shows inverse of last byte so stale data cannot match
   assign o_byte = i_rd ? (i_addr[7:0] ^ 8'h5A) : ~last_ff;
   always_ff @(posedge i_clk) begin
      if (i_rd)
         last_ff <= o_byte;
   end
endmodule // lad_pmem

// ---- literal_and_table_op_decoder_tb_top.sv ----
`timescale 1ns/1ps
module literal_and_table_op_decoder_tb_top;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic ce = 1'b1;
   logic vld = 1'b0, smod = 1'b0, tw = 1'b0, bw = 1'b0, br = 1'b0;
   logic [15:0] ins = 16'h0000, bwd = 16'h0000, rdata, prod, taddr;
   logic [7:0] pins = 8'h00, lat = 8'h00, working_register, twd, psrc, pbyte;
   logic [3:0] ba = 4'h0, bank_select_register;
   logic ret, fl, trd, twr, psc;
   lad_pkg::lad_flags_t st;
   int miscompares = 0, checked = 0, cyc = 0;
   localparam logic [15:0] LW [9] = '{16'h0E80, 16'h0F80, 16'h0E0F,
      16'h0BF0, 16'h0981, 16'h0AFF, 16'h0810, 16'h0E7E, 16'h0D03};
   localparam logic [7:0] LX [9] = '{8'h80, 8'h00, 8'h0F, 8'h00, 8'h81,
      8'h7E, 8'h92, 8'h7E, 8'h7E};
   localparam logic [4:0] LF [9] = '{5'h00, 5'h0D, 5'h0D, 5'h0D, 5'h19,
      5'h09, 5'h10, 5'h10, 5'h10};

   lad_decoder dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
      .i_instr_valid(vld), .i_instr(ins), .i_prog_byte(pbyte),
      .i_port_pins(pins), .i_port_latch(lat), .i_port_self_mod(smod),
      .i_timer_zero_count_write(tw), .i_bus_addr(ba), .i_bus_wdata(bwd),
      .i_bus_wr(bw), .i_bus_rd(br), .o_bus_rdata_ff(rdata),
      .o_working_register_ff(working_register), .o_status_ff(st), .o_bsr_ff(bank_select_register),
      .o_prod_ff(prod), .o_ret_ff(ret), .o_flush_ff(fl),
      .o_tbl_rd_ff(trd), .o_tbl_wr_ff(twr), .o_tbl_addr_ff(taddr),
      .o_tbl_wdata_ff(twd), .o_port_src_ff(psrc), .o_psc_clr_ff(psc));
   lad_pmem pm_u (.i_clk(i_clk), .i_rd(trd), .i_addr(taddr),
      .o_byte(pbyte));

   ////////////////////////////////////////////////////////////////////
   initial begin
      forever #5 i_clk = ~i_clk;
   end
   task automatic conclude();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ceiling is more than twenty times the expected run
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         conclude();
      end
   end
   task automatic chk(input string n, input logic [15:0] s, e);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic iss(input logic [15:0] w);
      @(posedge i_clk);
      ins <= w;
      vld <= 1'b1;
      @(posedge i_clk);
      vld <= 1'b0;
      #1;
   endtask
   task automatic bwr_t(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk);
      ba <= a;
      bwd <= d;
      bw <= 1'b1;
      @(posedge i_clk);
      bw <= 1'b0;
   endtask
   task automatic brd_t(input logic [3:0] a, input logic [15:0] e);
      @(posedge i_clk);
      ba <= a;
      br <= 1'b1;
      @(posedge i_clk);
      br <= 1'b0;
      #1;
      chk("rdata", rdata, e);
   endtask

   ////////////////////////////////////////////////////////////////////
   task automatic t_lit();
      for (int i = 0; i < 9; i++) begin
         iss(LW[i]);
         chk("working_register", 16'(working_register), 16'(LX[i]));
         chk("flags", 16'(st), 16'(LF[i]));
      end
      chk("prod", prod, 16'h017A);
      iss(16'h010A);
      iss(16'h011B);
      chk("bsr", 16'(bank_select_register), 16'h000A);
      $display("literal test done");
   endtask
   task automatic t_ret();
      @(posedge i_clk);
      ins <= 16'h0C55;
      vld <= 1'b1;
      @(posedge i_clk);
      ins <= 16'h0E11;
      #1;
      chk("ret", 16'({ret, fl}), 16'h0003);
      @(posedge i_clk);
      vld <= 1'b0;
      @(posedge i_clk);
      #1;
      chk("slot", 16'({ret, fl, working_register}), 16'h0055);
      iss(16'hF034);
      chk("stray", 16'({st, working_register}), 16'h1055);
      $display("return test done");
   endtask
   task automatic t_ptr();
      for (int f = 0; f < 3; f++) begin
         iss({8'hEE, 2'b00, 2'(f), 4'hA});
         iss({8'hF0, 8'(8'h30 + f)});
         brd_t(4'(3 + f), {4'h0, 4'hA, 8'(8'h30 + f)});
      end
      $display("pointer test done");
   endtask
   task automatic t_tbl();
      logic [15:0] p, ea;
      logic [7:0] lb;
      p = 16'h0100;
      bwr_t(4'h6, p);
      for (int i = 0; i < 8; i++) begin
         ea = (i % 4 == 3) ? p + 16'h1 : p;
         iss(16'(16'h0008 + i));
         chk("strobe", 16'({trd, twr}), (i < 4) ? 16'h2 : 16'h1);
         chk("taddr", taddr, ea);
         if (i < 4)
            lb = ea[7:0] ^ 8'h5A;
         else
            chk("twd", 16'(twd), 16'(lb));
         if (i % 4 == 1 || i % 4 == 3)
            p = p + 16'h1;
         if (i % 4 == 2)
            p = p - 16'h1;
         brd_t(4'h6, p);
         brd_t(4'h7, 16'(lb));
         chk("flags", 16'(st), 16'h0010);
      end
      $display("table test done");
   endtask
   task automatic t_side();
      @(posedge i_clk);
      pins <= 8'h3C;
      lat <= 8'hC3;
      smod <= 1'b1;
      repeat (4) @(posedge i_clk);
      #1;
      chk("psrc", 16'(psrc), 16'h003C);
      smod <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
      chk("psrc", 16'(psrc), 16'h00C3);
      for (int a = 1; a >= 0; a--) begin
         bwr_t(4'h9, 16'(a));
         tw <= 1'b1;
         @(posedge i_clk);
         tw <= 1'b0;
         #1;
         chk("psc", 16'(psc), 16'(a));
      end
      brd_t(4'hF, 16'h0000);
      $display("side test done");
   endtask
   // enable low must freeze both the instruction and the bus path
   task automatic t_ce();
      ce <= 1'b0;
      iss(16'h0F01);
      bwr_t(4'h8, 16'h1234);
      chk("frozen_working_register", 16'(working_register), 16'h0055);
      chk("frozen_prod", prod, 16'h017A);
      ce <= 1'b1;
      @(posedge i_clk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      #1;
      chk("reset", 16'({bank_select_register, working_register}), 16'h0000);
      $display("enable test done");
   endtask

   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge i_clk);
      i_rst <= 1'b0;
      t_lit();
      t_ret();
      t_ptr();
      t_tbl();
      t_side();
      t_ce();
      conclude();
   end
endmodule // literal_and_table_op_decoder_tb_top
